//--- logic/eqcs_pkg.sv
// shared constants, types and decode functions for the error queue block
package eqcs_pkg;

  localparam int EQCS_DEPTH = 8;
  localparam int EQCS_PTR_W = 3;
  localparam int EQCS_CNT_W = 4;
  localparam int EQCS_NSET = 6;

  // register byte offsets
  localparam logic [7:0] OFF_ERR_LOG = 8'h00;
  localparam logic [7:0] OFF_ERR_COUNT = 8'h04;
  localparam logic [7:0] OFF_ERR_NEXT = 8'h08;
  localparam logic [7:0] OFF_EVENT_STATUS = 8'h0C;
  localparam logic [7:0] OFF_RESTART = 8'h10;
  localparam logic [7:0] OFF_FAULT = 8'h14;
  localparam logic [7:0] OFF_VERSION = 8'h18;
  localparam logic [7:0] OFF_SERIAL = 8'h1C;
  localparam logic [7:0] OFF_MAC_OUI = 8'h20;
  localparam logic [7:0] OFF_MAC_UNIT = 8'h24;
  localparam logic [7:0] OFF_NET_USED = 8'h28;
  // settings: bus address, static net, gateway, subnet, socket port, auto flag
  localparam logic [7:0] SET_OFF [EQCS_NSET] = '{8'h40, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h54};
  localparam logic [31:0] SET_RST [EQCS_NSET] =
    '{32'h0000_0001, 32'hC0A8_0164, 32'hC0A8_0101, 32'hFFFF_FF00, 32'h0000_C549, 32'h0000_0000};
  localparam logic [31:0] SET_MIN [EQCS_NSET] =
    '{32'h0000_0001, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0001, 32'h0000_0000};
  localparam logic [31:0] SET_MAX [EQCS_NSET] =
    '{32'h0000_001E, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_FFFF, 32'h0000_0001};
  localparam int SET_BUS_ADDR = 0;
  localparam int SET_NET_ADDR = 1;
  localparam int SET_GATEWAY = 2;
  localparam int SET_SUBNET = 3;
  localparam int SET_PORT = 4;
  localparam int SET_AUTO = 5;

  // error codes, two's complement
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_CMD = 16'hFF9C;
  localparam logic [15:0] ERR_SYNTAX = 16'hFF9A;
  localparam logic [15:0] ERR_PARAM = 16'hFF94;
  localparam logic [15:0] ERR_RANGE = 16'hFF22;
  localparam logic [15:0] ERR_OVERFLOW = 16'hFEA2;
  localparam logic [15:0] ERR_QUERY = 16'hFE70;
  // class bounds: upper end and lower end of each hundred
  localparam logic [15:0] CLS_CMD_HI = 16'hFF9C;
  localparam logic [15:0] CLS_CMD_LO = 16'hFF39;
  localparam logic [15:0] CLS_EXE_HI = 16'hFF38;
  localparam logic [15:0] CLS_EXE_LO = 16'hFED5;
  localparam logic [15:0] CLS_DEV_HI = 16'hFED4;
  localparam logic [15:0] CLS_DEV_LO = 16'hFE71;
  localparam logic [15:0] CLS_QRY_HI = 16'hFE70;
  localparam logic [15:0] CLS_QRY_LO = 16'hFE0D;

  localparam int EVS_CMD_BIT = 5;
  localparam int EVS_EXE_BIT = 4;
  localparam int EVS_DEV_BIT = 3;
  localparam int EVS_QRY_BIT = 2;
  localparam int EVS_W = 8;
  localparam int MSG_LSB = 16;

  typedef enum logic [7:0] {
    EQCS_MSG_NONE, EQCS_MSG_CMD, EQCS_MSG_SYNTAX, EQCS_MSG_PARAM,
    EQCS_MSG_RANGE, EQCS_MSG_OVERFLOW, EQCS_MSG_QUERY, EQCS_MSG_OTHER
  } eqcs_msg_t;

  typedef struct packed {
    logic valid;
    logic [15:0] code;
  } eqcs_log_t;

  typedef struct packed {
    eqcs_msg_t msg;
    logic [15:0] code;
  } eqcs_entry_t;

  function automatic logic in_cls(input logic [15:0] c, input logic [15:0] hi,
                                  input logic [15:0] lo);
    in_cls = ($signed(c) <= $signed(hi)) && ($signed(c) >= $signed(lo));
  endfunction : in_cls

  function automatic logic [EVS_W-1:0] eqcs_class_bits(input logic [15:0] c);
    eqcs_class_bits = '0;
    eqcs_class_bits[EVS_CMD_BIT] = in_cls(c, CLS_CMD_HI, CLS_CMD_LO);
    eqcs_class_bits[EVS_EXE_BIT] = in_cls(c, CLS_EXE_HI, CLS_EXE_LO);
    eqcs_class_bits[EVS_DEV_BIT] = in_cls(c, CLS_DEV_HI, CLS_DEV_LO);
    eqcs_class_bits[EVS_QRY_BIT] = in_cls(c, CLS_QRY_HI, CLS_QRY_LO);
  endfunction : eqcs_class_bits

  function automatic eqcs_msg_t eqcs_msg_of(input logic [15:0] c);
    case (c)
      ERR_NONE: eqcs_msg_of = EQCS_MSG_NONE;
      ERR_CMD: eqcs_msg_of = EQCS_MSG_CMD;
      ERR_SYNTAX: eqcs_msg_of = EQCS_MSG_SYNTAX;
      ERR_PARAM: eqcs_msg_of = EQCS_MSG_PARAM;
      ERR_RANGE: eqcs_msg_of = EQCS_MSG_RANGE;
      ERR_OVERFLOW: eqcs_msg_of = EQCS_MSG_OVERFLOW;
      ERR_QUERY: eqcs_msg_of = EQCS_MSG_QUERY;
      default: eqcs_msg_of = EQCS_MSG_OTHER;
    endcase
  endfunction : eqcs_msg_of

endpackage : eqcs_pkg

//--- logic/eqcs_err_queue.sv
// first-in first-out store of error codes with overflow marker
`timescale 1ns/10ps
module eqcs_err_queue
  import eqcs_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire eqcs_log_t push,
  input wire logic pop,
  output logic [15:0] head,
  output logic [EQCS_CNT_W-1:0] count,
  output logic ovf_stored
);

  logic [15:0] mem [EQCS_DEPTH];
  logic [EQCS_PTR_W-1:0] rd_ptr;
  logic [EQCS_PTR_W-1:0] wr_ptr;
  logic pop_ok;
  logic store;
  logic [EQCS_CNT_W-1:0] eff;
  logic [15:0] wr_code;

  always_comb begin
    pop_ok = pop && (count != '0);
    eff = count - EQCS_CNT_W'(pop_ok);
    // a full queue drops new errors until a read frees a slot
    // RL21 drop when full
    store = push.valid && (eff < EQCS_CNT_W'(EQCS_DEPTH));
    // the last free slot takes the overflow marker, not the real error
    // RL5 overflow in last slot
    wr_code = (eff == EQCS_CNT_W'(EQCS_DEPTH - 1)) ? ERR_OVERFLOW : push.code;
    ovf_stored = store && (eff == EQCS_CNT_W'(EQCS_DEPTH - 1));
    head = (count != '0) ? mem[rd_ptr] : ERR_NONE;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count <= '0;
    end else begin
      rd_ptr <= rd_ptr + EQCS_PTR_W'(pop_ok);
      wr_ptr <= wr_ptr + EQCS_PTR_W'(store);
      count <= eff + EQCS_CNT_W'(store);
    end
  end

  always_ff @(posedge hclk) begin
    if (store) begin
      mem[wr_ptr] <= wr_code;
    end
  end

endmodule : eqcs_err_queue

//--- logic/eqcs_setting.sv
// one stored interface setting with range check and factory default
`timescale 1ns/10ps
module eqcs_setting
  import eqcs_pkg::*;
#(
  parameter logic [31:0] RST_VAL = 32'h0000_0000,
  parameter logic [31:0] MIN_VAL = 32'h0000_0000,
  parameter logic [31:0] MAX_VAL = 32'hFFFF_FFFF
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic wr_en,
  input wire logic [31:0] wdata,
  output logic [31:0] value,
  output logic reject
);

  logic in_range;

  always_comb begin
    in_range = (wdata >= MIN_VAL) && (wdata <= MAX_VAL);
    reject = wr_en && !in_range;
  end

  // an out-of-range write keeps the old value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      value <= RST_VAL;
    end else if (wr_en && in_range) begin
      value <= wdata;
    end
  end

endmodule : eqcs_setting

//--- logic/eqcs_top.sv
// error queue, event status and interface settings behind an AHB-Lite slave
//
// Contract
// RL1 - error count register reads the number of entries held in the queue
// RL2 - entries leave in arrival order, each a signed code plus message id
// RL3 - each read of the next-error register removes one entry
// RL4 - empty queue reads code 0 with the no-error message, queue unchanged
// RL5 - on overflow the last queue slot holds code -350
// RL6 - codes -100..-199 set event bit 5, -200..-299 set bit 4
// RL7 - codes -300..-399 set event bit 3, -400..-499 set bit 2
// RL8 - log -100 generic command, -102 unknown target, -108 extra parameter
// RL9 - log -222 for out-of-range values, -400 for a bad query
// RL10 - restart command pulses restart and clears latched hard faults
// RL11 - version reads boot loader, firmware, hardware revision in that order
// RL12 - instrument bus address accepts 1 to 30, defaults to 1
// RL13 - static net address holds four bytes, defaults 192.168.1.100
// RL14 - auto flag 1 uses the assigned address, 0 the static one
// RL15 - gateway holds four bytes, defaults 192.168.1.1
// RL16 - subnet mask holds four bytes, defaults 255.255.255.0
// RL17 - socket port accepts 1 to 65535, defaults 50505
// RL18 - host should pick socket ports above 49151
// RL19 - module serial number is read only, 1 to 16777215
// RL20 - hardware net address is read only, three vendor then three unit bytes
// RL21 - queue depth is a parameter; errors arriving while full are dropped
// RL22 - logging pushes and sets the class bit together; reads keep the bit
//
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
module eqcs_top
  import eqcs_pkg::*;
#(
  // arbitrary identity values
  parameter logic [7:0] BOOT_VER = 8'h01,
  parameter logic [7:0] FW_VER = 8'h02,
  parameter logic [7:0] HW_REV = 8'h03,
  parameter logic [23:0] MODULE_SERIAL = 24'h000001,
  parameter logic [23:0] MAC_OUI = 24'h000000,
  parameter logic [23:0] MAC_UNIT = 24'h000001
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic hard_fault_event,
  input wire logic [31:0] assigned_net_address,
  output logic hard_fault_latched,
  output logic system_restart_command,
  output logic [EVS_W-1:0] event_status_summary,
  output logic [4:0] instrument_bus_address_setting,
  output logic [31:0] net_address_in_use,
  output logic auto_addressing_flag,
  output logic [31:0] gateway_address,
  output logic [31:0] subnet_mask,
  output logic [15:0] socket_port
);

  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ
  } eqcs_bus_t;

  eqcs_bus_t bus_state;
  logic [7:0] addr_q;
  logic word_q;
  logic accept;

  eqcs_log_t log_req;
  logic pop;
  logic [15:0] q_head;
  logic [EQCS_CNT_W-1:0] q_count;
  logic q_ovf;

  logic [31:0] set_val [EQCS_NSET];
  logic [EQCS_NSET-1:0] set_wr;
  logic [EQCS_NSET-1:0] set_rej;

  logic wr_phase;
  logic rd_phase;
  logic wr_log;
  logic wr_restart;
  logic wr_evs;
  logic restart_go;
  logic wr_known;
  logic rd_known;
  logic [31:0] rd_word;
  logic [EVS_W-1:0] next_evs;
  eqcs_entry_t head_entry;

  // address decode shared by reads and writes
  function automatic logic is_setting(input logic [7:0] a);
    is_setting = 1'b0;
    for (int i = 0; i < EQCS_NSET; i++) begin
      if (a == SET_OFF[i]) begin
        is_setting = 1'b1;
      end
    end
  endfunction : is_setting

  // every offset that a read may name without a query error
  function automatic logic is_readable(input logic [7:0] a);
    case (a)
      OFF_ERR_COUNT, OFF_ERR_NEXT, OFF_EVENT_STATUS, OFF_FAULT, OFF_VERSION,
      OFF_SERIAL, OFF_MAC_OUI, OFF_MAC_UNIT, OFF_NET_USED: is_readable = 1'b1;
      default: is_readable = is_setting(a);
    endcase
  endfunction : is_readable

  // bus front end: writes finish with no wait, reads take one wait state
  // so that a read right behind a write sees the written value
  always_comb begin
    accept = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    wr_phase = (bus_state == BUS_WRITE);
    rd_phase = (bus_state == BUS_READ);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= BUS_IDLE;
      addr_q <= '0;
      word_q <= 1'b0;
    end else if (accept) begin
      bus_state <= hwrite ? BUS_WRITE : BUS_READ;
      addr_q <= haddr[7:0];
      word_q <= (hsize == HSIZE_WORD);
    end else if (rd_phase || wr_phase) begin
      bus_state <= BUS_IDLE;
    end
  end

  // one wait state on reads only; writes never stall the bus
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else if (accept && !hwrite) begin
      hreadyout <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  // only okay is ever answered; a flop keeps this pin registered like the rest
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // write decode
  always_comb begin
    wr_log = wr_phase && word_q && (addr_q == OFF_ERR_LOG);
    wr_restart = wr_phase && word_q && (addr_q == OFF_RESTART);
    wr_evs = wr_phase && word_q && (addr_q == OFF_EVENT_STATUS);
    // restart runs only with an empty argument
    restart_go = wr_restart && (hwdata == '0);
    // RL19 serial not writable
    // RL20 net address fixed
    wr_known = (addr_q == OFF_ERR_LOG) || (addr_q == OFF_RESTART)
      || (addr_q == OFF_EVENT_STATUS) || is_setting(addr_q);
    rd_known = is_readable(addr_q);
  end

  generate
    for (genvar g = 0; g < EQCS_NSET; g++) begin : g_set
      assign set_wr[g] = wr_phase && word_q && (addr_q == SET_OFF[g]);
      // RL12 range and default
      // RL13 static address default
      // RL15 gateway default
      // RL16 subnet default
      // RL17 port range default
      eqcs_setting #(
        .RST_VAL(SET_RST[g]),
        .MIN_VAL(SET_MIN[g]),
        .MAX_VAL(SET_MAX[g])
      ) u_set (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(set_wr[g]),
        .wdata(hwdata),
        .value(set_val[g]),
        .reject(set_rej[g])
      );
    end
  endgenerate

  // error sources; at most one fires per cycle since each comes from
  // exactly one bus data phase
  always_comb begin
    log_req = '0;
    if (wr_phase && !word_q) begin
      // RL8 generic command
      log_req = '{valid: 1'b1, code: ERR_CMD};
    end else if (wr_phase && !wr_known) begin
      // RL8 unknown target
      log_req = '{valid: 1'b1, code: ERR_SYNTAX};
    end else if (wr_restart && (hwdata != '0)) begin
      // RL8 extra parameter
      log_req = '{valid: 1'b1, code: ERR_PARAM};
    end else if (|set_rej) begin
      // RL9 out of range
      log_req = '{valid: 1'b1, code: ERR_RANGE};
    end else if (rd_phase && !rd_known) begin
      // RL9 bad query
      log_req = '{valid: 1'b1, code: ERR_QUERY};
    end else if (wr_log) begin
      log_req = '{valid: 1'b1, code: hwdata[15:0]};
    end
  end

  // RL3 pop on read
  assign pop = rd_phase && (addr_q == OFF_ERR_NEXT);

  // a pop and a push in one cycle are both honoured
  // RL21 depth fixed by package
  eqcs_err_queue u_queue (
    .hclk(hclk),
    .hresetn(hresetn),
    .push(log_req),
    .pop(pop),
    .head(q_head),
    .count(q_count),
    .ovf_stored(q_ovf)
  );

  // event status: set wins over write-one-to-clear
  always_comb begin
    next_evs = event_status_summary;
    if (wr_evs) begin
      next_evs = next_evs & ~hwdata[EVS_W-1:0];
    end
    if (log_req.valid) begin
      // RL6 class bits
      // RL7 class bits
      next_evs = next_evs | eqcs_class_bits(log_req.code);
    end
    // RL5 overflow class bit
    if (q_ovf) begin
      next_evs = next_evs | eqcs_class_bits(ERR_OVERFLOW);
    end
  end

  // RL22 set with push
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_status_summary <= '0;
    end else begin
      event_status_summary <= next_evs;
    end
  end

  // RL10 restart pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      system_restart_command <= 1'b0;
    end else begin
      system_restart_command <= restart_go;
    end
  end

  // RL10 fault clear; a new fault in the restart cycle still latches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hard_fault_latched <= 1'b0;
    end else if (hard_fault_event) begin
      hard_fault_latched <= 1'b1;
    end else if (restart_go) begin
      hard_fault_latched <= 1'b0;
    end
  end

  // setting outputs registered once more so every pin is a plain flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      instrument_bus_address_setting <= SET_RST[SET_BUS_ADDR][4:0];
      auto_addressing_flag <= SET_RST[SET_AUTO][0];
      gateway_address <= SET_RST[SET_GATEWAY];
      subnet_mask <= SET_RST[SET_SUBNET];
      socket_port <= SET_RST[SET_PORT][15:0];
      net_address_in_use <= SET_RST[SET_NET_ADDR];
    end else begin
      instrument_bus_address_setting <= set_val[SET_BUS_ADDR][4:0];
      auto_addressing_flag <= set_val[SET_AUTO][0];
      gateway_address <= set_val[SET_GATEWAY];
      subnet_mask <= set_val[SET_SUBNET];
      socket_port <= set_val[SET_PORT][15:0];
      // RL14 address select
      net_address_in_use <= set_val[SET_AUTO][0] ? assigned_net_address
                                                 : set_val[SET_NET_ADDR];
    end
  end

  // read mux
  always_comb begin
    // RL2 code with message
    // RL4 empty reads zero
    head_entry = '{msg: eqcs_msg_of(q_head), code: q_head};
    rd_word = '0;
    case (addr_q)
      // RL1 count
      OFF_ERR_COUNT: rd_word = {{(32 - EQCS_CNT_W){1'b0}}, q_count};
      OFF_ERR_NEXT: rd_word = {8'h00, head_entry};
      OFF_EVENT_STATUS: rd_word = {{(32 - EVS_W){1'b0}}, event_status_summary};
      OFF_FAULT: rd_word = {31'h0000_0000, hard_fault_latched};
      // RL11 version order
      OFF_VERSION: rd_word = {8'h00, BOOT_VER, FW_VER, HW_REV};
      // RL19 read only serial
      OFF_SERIAL: rd_word = {8'h00, MODULE_SERIAL};
      // RL20 vendor then unit
      OFF_MAC_OUI: rd_word = {8'h00, MAC_OUI};
      OFF_MAC_UNIT: rd_word = {8'h00, MAC_UNIT};
      OFF_NET_USED: rd_word = net_address_in_use;
      default: begin
        for (int i = 0; i < EQCS_NSET; i++) begin
          if (addr_q == SET_OFF[i]) begin
            rd_word = set_val[i];
          end
        end
      end
    endcase
  end

  // read data holds until the next read completes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (rd_phase) begin
      hrdata <= rd_word;
    end
  end

endmodule : eqcs_top

//--- tb/eqcs_props.sv
// concurrent checks on the error queue block ports
`timescale 1ns/10ps
module eqcs_props
  import eqcs_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hard_fault_event,
  input wire logic [31:0] assigned_net_address,
  input wire logic hard_fault_latched,
  input wire logic system_restart_command,
  input wire logic [EVS_W-1:0] event_status_summary,
  input wire logic [4:0] instrument_bus_address_setting,
  input wire logic [31:0] net_address_in_use,
  input wire logic auto_addressing_flag,
  input wire logic [15:0] socket_port
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // high during the data phase of a status write, the only legal way to clear
  logic evs_wr_dp;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evs_wr_dp <= 1'b0;
    end else if (hready) begin
      evs_wr_dp <= hsel && htrans[1] && hwrite && haddr[7:0] == OFF_EVENT_STATUS;
    end
  end
  chk_status_spare: assert property (
    event_status_summary[7:6] == 2'h0 && event_status_summary[1:0] == 2'h0)
    else $error("spare status bits set");
  chk_status_keep: assert property (
    |($past(event_status_summary) & ~event_status_summary) |-> $past(evs_wr_dp))
    else $error("status bit cleared without a status write");
  chk_restart_pulse: assert property (
    system_restart_command |=> !system_restart_command)
    else $error("restart longer than one cycle");
  chk_fault_clear: assert property (
    $rose(system_restart_command) && !$past(hard_fault_event) |-> !hard_fault_latched)
    else $error("restart left the fault latched");
  chk_fault_latch: assert property (
    hard_fault_event |=> hard_fault_latched)
    else $error("fault event not latched");
  chk_bus_range: assert property (
    instrument_bus_address_setting inside {[5'h01:5'h1E]})
    else $error("bus address out of range");
  chk_port_nonzero: assert property (
    socket_port != 16'h0000)
    else $error("socket port zero");
  chk_net_auto: assert property (
    auto_addressing_flag |-> net_address_in_use == $past(assigned_net_address))
    else $error("assigned address not in use");
  cover property (system_restart_command);
  cover property (auto_addressing_flag);
  cover property ($fell(event_status_summary[4]));
endmodule : eqcs_props
bind eqcs_top eqcs_props chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hard_fault_event, .assigned_net_address, .hard_fault_latched, .system_restart_command,
  .event_status_summary, .instrument_bus_address_setting, .net_address_in_use,
  .auto_addressing_flag, .socket_port);

//--- tb/eqcs_host.sv
// remote host model issuing single transfers of the size the caller picks
`timescale 1ns/10ps
module eqcs_host (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // caller enters right after a rising edge; no wait count is assumed
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic [2:0] sz, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= sz;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : xfer
endmodule : eqcs_host

//--- tb/tb.sv
// self-checking bench for the error queue and settings block
`timescale 1ns/10ps
module tb;
  import eqcs_pkg::*;
  logic hclk;
  logic hresetn;
  logic hard_fault_event;
  logic [31:0] assigned_net_address;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic hard_fault_latched;
  logic system_restart_command;
  logic [EVS_W-1:0] event_status_summary;
  logic [4:0] instrument_bus_address_setting;
  logic [31:0] net_address_in_use;
  logic auto_addressing_flag;
  logic [31:0] gateway_address;
  logic [31:0] subnet_mask;
  logic [15:0] socket_port;
  int miscompares;
  int checks;
  int cycles;
  int pulses;
  eqcs_host h (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata);
  eqcs_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .hard_fault_event, .assigned_net_address,
    .hard_fault_latched, .system_restart_command, .event_status_summary,
    .instrument_bus_address_setting, .net_address_in_use, .auto_addressing_flag,
    .gateway_address, .subnet_mask, .socket_port);
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  task automatic results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  // a run of these tests needs well under a thousand cycles
  always @(posedge hclk) begin
    cycles++;
    if (system_restart_command === 1'b1) pulses++;
    if (cycles == 5000) begin
      miscompares++;
      results();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    h.xfer(a, 1'b1, d, 3'h2, r);
  endtask : wr
  task automatic rk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    h.xfer(a, 1'b0, 32'h0, 3'h2, r);
    cmp(r, e);
    cmp(32'(hresp), 32'h0);
  endtask : rk
  task automatic pop(input logic [7:0] m, input logic [15:0] c);
    rk(OFF_ERR_NEXT, {8'h00, m, c});
  endtask : pop
  task automatic t_defaults;
    cmp(32'(instrument_bus_address_setting), 32'h1);
    cmp(gateway_address, 32'hC0A8_0101);
    cmp(subnet_mask, 32'hFFFF_FF00);
    cmp(32'(socket_port), 32'h0000_C549);
    cmp(32'(auto_addressing_flag), 32'h0);
    rk(8'h44, 32'hC0A8_0164);
    rk(OFF_NET_USED, 32'hC0A8_0164);
    $display("done defaults");
  endtask : t_defaults
  task automatic t_fifo;
    logic [15:0] c [4];
    logic [7:0] m [4];
    c = '{16'hFF9C, 16'hFF22, 16'hFED4, 16'hFE70};
    m = '{8'h01, 8'h04, 8'h07, 8'h06};
    foreach (c[i]) wr(OFF_ERR_LOG, {16'h0000, c[i]});
    rk(OFF_EVENT_STATUS, 32'h3C);
    rk(OFF_ERR_COUNT, 32'h4);
    foreach (c[i]) begin
      pop(m[i], c[i]);
      rk(OFF_ERR_COUNT, 32'(3 - i));
    end
    rk(OFF_EVENT_STATUS, 32'h3C);
    wr(OFF_EVENT_STATUS, 32'h3C);
    pop(8'h00, 16'h0000);
    rk(OFF_ERR_COUNT, 32'h0);
    $display("done fifo");
  endtask : t_fifo
  task automatic t_overflow;
    repeat (9) wr(OFF_ERR_LOG, 32'h0000_FF9A);
    rk(OFF_ERR_COUNT, 32'h8);
    repeat (7) pop(8'h02, 16'hFF9A);
    pop(8'h05, 16'hFEA2);
    rk(OFF_ERR_COUNT, 32'h0);
    rk(OFF_EVENT_STATUS, 32'h28);
    wr(OFF_EVENT_STATUS, 32'hFF);
    $display("done overflow");
  endtask : t_overflow
  task automatic t_errors;
    logic [31:0] r;
    wr(OFF_SERIAL, 32'h5);
    rk(OFF_ERR_LOG, 32'h0);
    wr(8'h40, 32'h1F);
    wr(8'h40, 32'h0);
    wr(OFF_RESTART, 32'h1);
    h.xfer(8'h40, 1'b1, 32'h5, 3'h0, r);
    wr(OFF_MAC_OUI, 32'h7);
    pop(8'h02, 16'hFF9A);
    pop(8'h06, 16'hFE70);
    pop(8'h04, 16'hFF22);
    pop(8'h04, 16'hFF22);
    pop(8'h03, 16'hFF94);
    pop(8'h01, 16'hFF9C);
    pop(8'h02, 16'hFF9A);
    rk(OFF_SERIAL, 32'h1);
    rk(8'h40, 32'h1);
    cmp(32'(pulses), 32'h0);
    wr(OFF_EVENT_STATUS, 32'hFF);
    $display("done errors");
  endtask : t_errors
  task automatic t_restart;
    hard_fault_event <= 1'b1;
    @(posedge hclk);
    hard_fault_event <= 1'b0;
    repeat (2) @(posedge hclk);
    rk(OFF_FAULT, 32'h1);
    wr(OFF_RESTART, 32'h0);
    repeat (2) @(posedge hclk);
    cmp(32'(hard_fault_latched), 32'h0);
    cmp(32'(pulses), 32'h1);
    rk(OFF_VERSION, 32'h0001_0203);
    rk(OFF_MAC_OUI, 32'h0);
    rk(OFF_MAC_UNIT, 32'h1);
    $display("done restart");
  endtask : t_restart
  task automatic t_settings;
    // the host keeps its port above the registered range
    wr(8'h50, 32'h0000_C54A);
    wr(8'h50, 32'h0);
    wr(8'h48, 32'h0A00_0001);
    wr(8'h4C, 32'hFFFF_0000);
    wr(8'h44, 32'hC0A8_0A02);
    repeat (2) @(posedge hclk);
    cmp(32'(socket_port), 32'h0000_C54A);
    cmp(gateway_address, 32'h0A00_0001);
    cmp(subnet_mask, 32'hFFFF_0000);
    rk(OFF_NET_USED, 32'hC0A8_0A02);
    assigned_net_address <= 32'h0A00_0005;
    wr(8'h54, 32'h1);
    wr(8'h54, 32'h2);
    repeat (3) @(posedge hclk);
    cmp(net_address_in_use, 32'h0A00_0005);
    wr(8'h54, 32'h0);
    repeat (3) @(posedge hclk);
    cmp(net_address_in_use, 32'hC0A8_0A02);
    pop(8'h04, 16'hFF22);
    pop(8'h04, 16'hFF22);
    $display("done settings");
  endtask : t_settings
  initial begin
    hresetn = 1'b0;
    hard_fault_event = 1'b0;
    assigned_net_address = 32'h0A0A_0A0A;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_defaults();
    t_fifo();
    t_overflow();
    t_errors();
    t_restart();
    t_settings();
    results();
  end
endmodule : tb
